// ---- include/swv_defines.svh ----
`ifndef SWV_DEFINES_SVH
`define SWV_DEFINES_SVH

// ==========================================================
// command codes on the link
`define SWV_CMD_WRITE_SP 8'h0f
`define SWV_CMD_READ_SP 8'haa
`define SWV_CMD_COPY_SP 8'h99

// ==========================================================
// scratchpad and status byte layout
`define SWV_LAST_OFFSET 5'h1f
`define SWV_ES_AA_BIT 7
`define SWV_ES_ZERO_BIT 6
`define SWV_ES_PF_BIT 5
`define SWV_CRC_INIT 16'h0000
`define SWV_CRC_POLY 16'ha001
`define SWV_REG_PAGE_TAG 10'h010

// ==========================================================
// slot kinds
`define SWV_SLOT_RESET 2'h0
`define SWV_SLOT_WRITE 2'h1
`define SWV_SLOT_READ 2'h2

// ==========================================================
// timing
`define SWV_CLK_PERIOD_NS 40
`define SWV_COPY_BYTE_NS 2000
`define SWV_COPY_BYTE_CYC ((`SWV_COPY_BYTE_NS + `SWV_CLK_PERIOD_NS - 1) / `SWV_CLK_PERIOD_NS)
`define SWV_SLOT_CYC_STD 16
`define SWV_SLOT_CYC_OD 2

// ==========================================================
// controller registers on apb
`define SWV_APB_CMD 12'h000
`define SWV_APB_STATUS 12'h004
`define SWV_OP_RESET 2'h0
`define SWV_OP_WRITE 2'h1
`define SWV_OP_READ 2'h2

`endif

// ---- include/swv_pkg.sv ----
package swv_pkg;

  // ==========================================================
  // device end
  typedef enum logic [11:0] {
    SWV_IDLE    = 12'h001,
    SWV_WS_ADDR = 12'h002,
    SWV_WS_DATA = 12'h004,
    SWV_CRC_OUT = 12'h008,
    SWV_RS_HDR  = 12'h010,
    SWV_RS_DATA = 12'h020,
    SWV_ONES    = 12'h040,
    SWV_CP_AUTH = 12'h080,
    SWV_CP_PW   = 12'h100,
    SWV_COPY    = 12'h200,
    SWV_ALT     = 12'h400,
    SWV_HALT    = 12'h800
  } swv_dev_state_t;

  typedef struct packed {
    swv_dev_state_t st;
    logic [15:0] ta;
    logic [4:0] es_e;
    logic pf;
    logic aa;
    logic od;
    logic [15:0] crc;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic [3:0] idx;
    logic [4:0] ptr;
    logic mism_auth;
    logic mism_pw;
    logic [7:0] wcnt;
    logic [7:0] ccnt;
    logic pend;
    logic [1:0] pkind;
    logic pwbit;
    logic ack;
    logic rbit;
    logic alt;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [31:0][7:0] spad;
  } swv_dev_t;

  // ==========================================================
  // host end
  typedef enum logic [2:0] {
    SWV_H_IDLE  = 3'h1,
    SWV_H_ISSUE = 3'h2,
    SWV_H_WAIT  = 3'h4
  } swv_host_state_t;

  typedef struct packed {
    swv_host_state_t st;
    logic [1:0] op;
    logic [7:0] sh;
    logic [2:0] nbits;
    logic [2:0] cnt;
    logic [7:0] rx;
    logic [13:0] cmd;
    logic req;
    logic [1:0] kind;
    logic wbit;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } swv_host_t;

endpackage

// ---- include/swv_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// slot level link between bus master and device
interface swv_link_if;
  logic slot_req;
  logic [1:0] slot_kind;
  logic slot_wbit;
  logic slot_ack;
  logic slot_rbit;

  modport dev (input slot_req, input slot_kind, input slot_wbit,
               output slot_ack, output slot_rbit);
  modport host (output slot_req, output slot_kind, output slot_wbit,
                input slot_ack, input slot_rbit);
endinterface

`default_nettype wire

// ---- rtl/swv_device.sv ----
// Added by the designer: the memory write port and the copy timing parameter.
`timescale 1ns/1ps
`default_nettype none
`include "swv_defines.svh"

module swv_device
  import swv_pkg::*;
#(
  parameter int SLOT_CYC_STD = `SWV_SLOT_CYC_STD,
  parameter int SLOT_CYC_OD = `SWV_SLOT_CYC_OD,
  parameter int COPY_CYC = `SWV_COPY_BYTE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link to the bus master
  swv_link_if.dev link,
  // security and mission context
  input wire logic passwords_enabled,
  input wire logic [63:0] full_access_pw,
  input wire logic mission_active,
  input wire logic internal_busy,
  // speed selection from the rom layer
  input wire logic od_set,
  input wire logic od_clr,
  output logic overdrive_select,
  // memory write port
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata
);

  // ==========================================================
  // parameter checks
  if (SLOT_CYC_STD < 1 || SLOT_CYC_STD > 256 || SLOT_CYC_OD < 1 || SLOT_CYC_OD > 256) begin : g_bad_slot
    $error("slot cycle counts must lie in 1..256");
  end
  if (COPY_CYC < 1 || COPY_CYC > 256) begin : g_bad_copy
    $error("copy cycle count must lie in 1..256");
  end

  localparam logic [7:0] STD_LAT = 8'(SLOT_CYC_STD - 1);
  localparam logic [7:0] OD_LAT = 8'(SLOT_CYC_OD - 1);
  localparam logic [7:0] COPY_LAT = 8'(COPY_CYC - 1);

  // ==========================================================
  // helpers
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic d);
    logic [15:0] r;
    r = {1'b0, c[15:1]};
    if (c[0] ^ d) begin
      r = r ^ `SWV_CRC_POLY;
    end
    return r;
  endfunction

  function automatic logic [7:0] hdr_byte(input logic [1:0] i, input logic [15:0] t,
                                          input logic [7:0] s);
    logic [7:0] r;
    case (i)
      2'h0: r = t[7:0];
      2'h1: r = t[15:8];
      default: r = s;
    endcase
    return r;
  endfunction

  swv_dev_t q;
  swv_dev_t next_q;
  logic [7:0] b;
  logic [7:0] es;
  logic [7:0] tx;
  logic [7:0] pw_byte;
  logic bitv;
  logic rx_st;
  logic crc_st;
  logic reg_page;

  // ==========================================================
  // next state
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.mem_we = 1'b0;
    b = {q.pwbit, q.sh[7:1]};
    es = {q.aa, 1'b0, q.pf, q.es_e};
    tx = (q.st == SWV_RS_HDR) ? hdr_byte(q.idx[1:0], q.ta, es) : q.spad[q.ptr];
    pw_byte = full_access_pw[{q.idx[2:0], 3'h0} +: 8];
    bitv = 1'b1;
    rx_st = (q.st == SWV_IDLE) || (q.st == SWV_WS_ADDR) || (q.st == SWV_WS_DATA) ||
            (q.st == SWV_CP_AUTH) || (q.st == SWV_CP_PW);
    crc_st = (q.st == SWV_IDLE) || (q.st == SWV_WS_ADDR) || (q.st == SWV_WS_DATA);
    reg_page = (q.ta[15:6] == `SWV_REG_PAGE_TAG);

    if (od_set) begin
      next_q.od = 1'b1;
    end else if (od_clr) begin
      next_q.od = 1'b0;
    end

    // copy engine waits while sampling owns the memory
    if (q.st == SWV_COPY) begin
      if (q.ccnt != 8'h00) begin
        next_q.ccnt = q.ccnt - 8'h01;
      end else if (!internal_busy) begin
        next_q.mem_we = 1'b1;
        next_q.mem_addr = {q.ta[15:5], q.ptr};
        next_q.mem_wdata = q.spad[q.ptr];
        next_q.ccnt = COPY_LAT;
        if (q.ptr == q.es_e) begin
          next_q.st = SWV_ALT;
          next_q.alt = 1'b1;
        end else begin
          next_q.ptr = q.ptr + 5'h01;
        end
      end
    end

    // slot timing follows the selected speed
    if (!q.pend && link.slot_req) begin
      next_q.pend = 1'b1;
      next_q.pkind = link.slot_kind;
      next_q.pwbit = link.slot_wbit;
      next_q.wcnt = q.od ? OD_LAT : STD_LAT;
    end else if (q.pend && q.wcnt != 8'h00) begin
      next_q.wcnt = q.wcnt - 8'h01;
    end else if (q.pend) begin
      next_q.pend = 1'b0;
      next_q.ack = 1'b1;
      if (q.st == SWV_COPY) begin
        bitv = 1'b1;
      end else if (q.pkind == `SWV_SLOT_RESET) begin
        if (q.st == SWV_WS_DATA && q.bitn != 3'h0) begin
          next_q.pf = 1'b1;
        end
        next_q.st = SWV_IDLE;
        next_q.bitn = 3'h0;
        next_q.crc = `SWV_CRC_INIT;
      end else if (q.pkind == `SWV_SLOT_WRITE) begin
        if (rx_st) begin
          next_q.sh = b;
          next_q.bitn = q.bitn + 3'h1;
          if (crc_st) begin
            next_q.crc = crc_bit(q.crc, q.pwbit);
          end
          if (q.bitn == 3'h7) begin
            case (q.st)
              SWV_IDLE: begin
                next_q.idx = 4'h0;
                if (b == `SWV_CMD_WRITE_SP) begin
                  next_q.st = SWV_WS_ADDR;
                  next_q.aa = 1'b0;
                  next_q.pf = 1'b0;
                end else if (b == `SWV_CMD_READ_SP) begin
                  next_q.st = SWV_RS_HDR;
                end else if (b == `SWV_CMD_COPY_SP) begin
                  next_q.st = SWV_CP_AUTH;
                  next_q.mism_auth = 1'b0;
                  next_q.mism_pw = 1'b0;
                end else begin
                  next_q.st = SWV_HALT;
                end
              end
              SWV_WS_ADDR: begin
                next_q.idx = q.idx + 4'h1;
                if (q.idx == 4'h0) begin
                  next_q.ta[7:0] = b;
                end else begin
                  next_q.ta[15:8] = b;
                  next_q.ptr = q.ta[4:0];
                  next_q.es_e = q.ta[4:0];
                  next_q.st = SWV_WS_DATA;
                end
              end
              SWV_WS_DATA: begin
                next_q.spad[q.ptr] = b;
                next_q.es_e = q.ptr;
                if (q.ptr == `SWV_LAST_OFFSET) begin
                  next_q.st = SWV_CRC_OUT;
                  next_q.idx = 4'h0;
                end else begin
                  next_q.ptr = q.ptr + 5'h01;
                end
              end
              SWV_CP_AUTH: begin
                next_q.idx = q.idx + 4'h1;
                if (b != hdr_byte(q.idx[1:0], q.ta, es)) begin
                  next_q.mism_auth = 1'b1;
                end
                if (q.idx == 4'h2) begin
                  next_q.st = SWV_CP_PW;
                  next_q.idx = 4'h0;
                end
              end
              SWV_CP_PW: begin
                next_q.idx = q.idx + 4'h1;
                next_q.mism_pw = q.mism_pw | (b != pw_byte);
                if (q.idx == 4'h7) begin
                  if (passwords_enabled && next_q.mism_pw) begin
                    next_q.st = SWV_HALT;
                  end else if (!q.mism_auth && q.es_e == `SWV_LAST_OFFSET &&
                               !(mission_active && reg_page)) begin
                    next_q.aa = 1'b1;
                    next_q.st = SWV_COPY;
                    next_q.ptr = q.ta[4:0];
                    next_q.ccnt = COPY_LAT;
                  end else begin
                    next_q.st = SWV_ONES;
                  end
                end
              end
              default: begin
                next_q.st = SWV_HALT;
              end
            endcase
          end
        end
      end else begin
        case (q.st)
          SWV_RS_HDR, SWV_RS_DATA: begin
            bitv = tx[q.bitn];
            next_q.crc = crc_bit(q.crc, tx[q.bitn]);
            next_q.bitn = q.bitn + 3'h1;
            if (q.bitn == 3'h7) begin
              if (q.st == SWV_RS_HDR) begin
                next_q.idx = q.idx + 4'h1;
                if (q.idx == 4'h2) begin
                  next_q.st = SWV_RS_DATA;
                  next_q.ptr = q.ta[4:0];
                end
              end else if (q.ptr == `SWV_LAST_OFFSET) begin
                next_q.st = SWV_CRC_OUT;
                next_q.idx = 4'h0;
              end else begin
                next_q.ptr = q.ptr + 5'h01;
              end
            end
          end
          SWV_CRC_OUT: begin
            bitv = ~q.crc[0];
            next_q.crc = {1'b0, q.crc[15:1]};
            next_q.idx = q.idx + 4'h1;
            if (q.idx == 4'hf) begin
              next_q.st = SWV_ONES;
            end
          end
          SWV_ALT: begin
            bitv = q.alt;
            next_q.alt = ~q.alt;
          end
          default: begin
            bitv = 1'b1;
          end
        endcase
      end
      next_q.rbit = bitv;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= SWV_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign link.slot_ack = q.ack;
  assign link.slot_rbit = q.rbit;
  assign overdrive_select = q.od;
  assign mem_we = q.mem_we;
  assign mem_addr = q.mem_addr;
  assign mem_wdata = q.mem_wdata;

endmodule

`default_nettype wire

// ---- rtl/swv_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "swv_defines.svh"

module swv_host
  import swv_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // link to the device
  swv_link_if.host link
);

  swv_host_t q;
  swv_host_t next_q;
  logic acc;
  logic busy;

  // ==========================================================
  // apb access and slot sequencer
  always_comb begin
    next_q = q;
    next_q.req = 1'b0;
    acc = psel && penable;
    busy = (q.st != SWV_H_IDLE);

    // one wait state so read data comes from a flop
    if (acc && !q.pready) begin
      next_q.pready = 1'b1;
      next_q.pslverr = 1'b0;
      case (paddr)
        `SWV_APB_CMD: next_q.prdata = {18'h0, q.cmd};
        `SWV_APB_STATUS: next_q.prdata = {16'h0, q.rx, 7'h0, busy};
        default: begin
          next_q.prdata = 32'h0;
          next_q.pslverr = 1'b1;
        end
      endcase
    end else if (q.pready) begin
      next_q.pready = 1'b0;
      next_q.pslverr = 1'b0;
      // a new command while busy is dropped
      if (acc && pwrite && paddr == `SWV_APB_CMD && !busy && pwdata[13:12] != 2'h3) begin
        next_q.cmd = pwdata[13:0];
        next_q.op = pwdata[13:12];
        next_q.sh = pwdata[7:0];
        next_q.nbits = pwdata[10:8];
        next_q.cnt = 3'h0;
        next_q.st = SWV_H_ISSUE;
      end
    end

    case (q.st)
      SWV_H_IDLE: begin
        next_q.st = next_q.st;
      end
      SWV_H_ISSUE: begin
        next_q.req = 1'b1;
        next_q.wbit = q.sh[0];
        case (q.op)
          `SWV_OP_RESET: next_q.kind = `SWV_SLOT_RESET;
          `SWV_OP_READ: next_q.kind = `SWV_SLOT_READ;
          default: next_q.kind = `SWV_SLOT_WRITE;
        endcase
        next_q.st = SWV_H_WAIT;
      end
      SWV_H_WAIT: begin
        if (link.slot_ack) begin
          next_q.rx = {link.slot_rbit, q.rx[7:1]};
          next_q.sh = {1'b0, q.sh[7:1]};
          next_q.cnt = q.cnt + 3'h1;
          if (q.op == `SWV_OP_RESET || q.cnt == q.nbits) begin
            next_q.st = SWV_H_IDLE;
          end else begin
            next_q.st = SWV_H_ISSUE;
          end
        end
      end
      default: begin
        next_q.st = SWV_H_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= SWV_H_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign link.slot_req = q.req;
  assign link.slot_kind = q.kind;
  assign link.slot_wbit = q.wbit;

endmodule

`default_nettype wire

// ---- bench/swv_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// link timing and copy port checks
module swv_link_assertions #(
  parameter int SLOT_STD = 16,
  parameter int SLOT_OD = 2,
  parameter int COPY_CYC = 50
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  input wire logic slot_req,
  input wire logic [1:0] slot_kind,
  input wire logic slot_ack,
  input wire logic slot_rbit,
  // device side
  input wire logic od_set,
  input wire logic od_clr,
  input wire logic overdrive_select,
  input wire logic mission_active,
  input wire logic internal_busy,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // answer flop loads one edge after the slot counter runs out
  localparam int ACK_STD = SLOT_STD + 1;
  localparam int ACK_OD = SLOT_OD + 1;

  // cycles since last memory write; saturates so idle time never wraps
  logic [15:0] gap;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gap <= 16'hffff;
    end else if (mem_we) begin
      gap <= 16'h0001;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end

  sequence s_req_std;
    slot_req && !overdrive_select;
  endsequence
  sequence s_req_od;
    slot_req && overdrive_select;
  endsequence

  AST_ACK_STD: assert property (s_req_std |-> ##ACK_STD slot_ack)
    else $error("standard slot answer off time");
  AST_ACK_OD: assert property (s_req_od |-> ##ACK_OD slot_ack)
    else $error("overdrive slot answer off time");
  AST_RBIT_IDLE: assert property (slot_ack && slot_kind != 2'h2 |-> slot_rbit)
    else $error("non-read slot returned zero");
  AST_OD_SET: assert property (od_set |=> overdrive_select)
    else $error("overdrive not selected");
  AST_OD_CLR: assert property (od_clr && !od_set |=> !overdrive_select)
    else $error("overdrive not cleared");
  AST_OD_HOLD: assert property (!od_set && !od_clr |=> $stable(overdrive_select))
    else $error("speed changed by itself");
  AST_WE_PULSE: assert property (mem_we |=> !mem_we)
    else $error("memory write longer than one cycle");
  AST_WE_GAP: assert property (mem_we |-> gap >= COPY_CYC)
    else $error("copy bytes too close");
  AST_WE_STALL: assert property (internal_busy && $past(internal_busy) |-> !mem_we)
    else $error("copy wrote while sampling owned memory");
  AST_REG_PG: assert property (mem_we |-> mem_addr[15:6] != 10'h010 || !mission_active)
    else $error("register page written during mission");
endmodule

`default_nettype wire

// ---- bench/scratchpad_write_verify_copy_test.sv ----
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end

module scratchpad_write_verify_copy_test;
  // ==========================================================
  // bench state
  logic ref_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pw_en = 1'h0, mission = 1'h0, busy_in = 1'h0, od_set = 1'h0, od_clr = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, seed = 32'h5e6c8034, prdata, rd;
  logic [63:0] pw = 64'h0;
  logic pready, pslverr, ovd, we, err;
  logic [15:0] maddr, ta, c;
  logic [7:0] mdata, es;
  logic [7:0] sp [32] = '{default: 8'h00};
  int bad_count = 0, checked = 0, cyc = 0, nwe = 0;

  swv_link_if lnk ();
  swv_host i_swv_host (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .link(lnk));
  swv_device #(.SLOT_CYC_STD(4), .SLOT_CYC_OD(2), .COPY_CYC(24)) i_swv_device (
    .ref_clk(ref_clk), .reset(reset), .link(lnk), .passwords_enabled(pw_en),
    .full_access_pw(pw), .mission_active(mission), .internal_busy(busy_in), .od_set(od_set),
    .od_clr(od_clr), .overdrive_select(ovd), .mem_we(we), .mem_addr(maddr), .mem_wdata(mdata));
  swv_link_assertions #(.SLOT_STD(4), .SLOT_OD(2), .COPY_CYC(24)) i_swv_link_assertions (
    .ref_clk(ref_clk), .reset(reset), .slot_req(lnk.slot_req), .slot_kind(lnk.slot_kind),
    .slot_ack(lnk.slot_ack), .slot_rbit(lnk.slot_rbit), .od_set(od_set), .od_clr(od_clr),
    .overdrive_select(ovd), .mission_active(mission), .internal_busy(busy_in),
    .mem_we(we), .mem_addr(maddr));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // busy pattern stalls copies about a quarter of the time
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    busy_in <= cyc[3] & cyc[1];
    if (we) begin
      `CHK(maddr, {ta[15:5], 5'(ta[4:0] + nwe)})
      `CHK(mdata, sp[5'(ta[4:0] + nwe)])
      nwe++;
    end
    if (cyc == 90000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // reference helpers and bus tasks
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [15:0] crc8(input logic [15:0] k, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      k = (k[0] ^ d[i]) ? ((k >> 1) ^ 16'ha001) : (k >> 1);
    end
    return k;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic xfer(input logic [1:0] op, input logic [7:0] d, input logic [2:0] n);
    apb(1'h1, 12'h000, {18'h0, op, 1'h0, n, d});
    rd = 32'h1;
    while (rd[0] === 1'h1) apb(1'h0, 12'h004, 32'h0);
  endtask

  task automatic wbc(input logic [7:0] b);
    xfer(2'h1, b, 3'h7);
    c = crc8(c, b);
  endtask

  task automatic rbc(input logic [7:0] b);
    xfer(2'h2, 8'hff, 3'h7);
    `CHK(rd[15:8], b)
    c = crc8(c, b);
  endtask

  task automatic rcrc();
    logic [15:0] k;
    k = ~c;
    xfer(2'h2, 8'hff, 3'h7);
    `CHK(rd[15:8], k[7:0])
    xfer(2'h2, 8'hff, 3'h7);
    `CHK(rd[15:8], k[15:8])
  endtask

  task automatic wr_sp(input logic [15:0] t, input int n);
    ta = t;
    es = {3'h0, t[4:0]};
    xfer(2'h0, 8'h00, 3'h0);
    c = 16'h0000;
    wbc(8'h0f);
    wbc(t[7:0]);
    wbc(t[15:8]);
    for (int i = 0; i < n; i++) begin
      es[4:0] = t[4:0] + 5'(i);
      sp[es[4:0]] = 8'(rnd());
      wbc(sp[es[4:0]]);
    end
    if (n > 0 && es[4:0] == 5'h1f) rcrc();
  endtask

  task automatic rd_sp();
    xfer(2'h0, 8'h00, 3'h0);
    c = 16'h0000;
    wbc(8'haa);
    rbc(ta[7:0]);
    rbc(ta[15:8]);
    rbc(es);
    for (int i = ta[4:0]; i < 32; i++) rbc(sp[i]);
    rcrc();
    rbc(8'hff);
  endtask

  task automatic cp(input logic [7:0] pat, input logic [63:0] p, input int nexp);
    xfer(2'h0, 8'h00, 3'h0);
    wbc(8'h99);
    wbc(ta[7:0]);
    wbc(ta[15:8]);
    wbc(pat);
    for (int i = 0; i < 8; i++) wbc(p[8*i +: 8]);
    nwe = 0;
    // a reset slot lands mid copy and must change nothing
    if (nexp > 0) xfer(2'h0, 8'h00, 3'h0);
    for (int k = 0; k < 4000 && nwe < nexp; k++) @(posedge ref_clk);
    xfer(2'h2, 8'hff, 3'h7);
    `CHK(nwe, nexp)
    `CHK(rd[15:8], (nexp > 0) ? 8'h55 : 8'hff)
    if (nexp > 0) es[7] = 1'h1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [4:0] o;
    repeat (10) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    `CHK(ovd, 1'h0)
    apb(1'h1, 12'h004, 32'hffff_ffff);
    apb(1'h0, 12'h00c, 32'h0);
    `CHK({err, rd}, {1'h1, 32'h0})
    for (int r = 0; r < 4; r++) begin
      o = (r == 0) ? 5'h00 : (r == 1) ? 5'h1f : (r == 2) ? 5'h1c : 5'(rnd());
      pw <= {rnd(), rnd()};
      pw_en <= r[0];
      wr_sp({8'(rnd()), 3'(rnd()), o}, 32 - o);
      rd_sp();
      cp(es, pw, 32 - o);
      rd_sp();
    end
    pw_en <= 1'h1;
    // none of the next copies may write, whatever the mission state, except the last one to 16'h0100
    mission <= 1'(rnd());
    wr_sp(16'h0140, 32);
    cp(es ^ 8'h01, pw, 0);
    rd_sp();
    cp(es, ~pw, 0);
    rd_sp();
    wr_sp(16'h0020, 3);
    cp(es, pw, 0);
    wr_sp(16'h013a, 0);
    xfer(2'h1, 8'(rnd()), 3'h2);
    es[5] = 1'h1;
    rd_sp();
    mission <= 1'h1;
    wr_sp(16'h0400, 32);
    rd_sp();
    cp(es, pw, 0);
    rd_sp();
    wr_sp(16'h0100, 32);
    cp(es, pw, 32);
    mission <= 1'h0;
    // a clear in the same cycle as a set must lose
    od_set <= 1'h1;
    od_clr <= 1'(rnd());
    @(posedge ref_clk);
    od_set <= 1'h0;
    od_clr <= 1'h0;
    wr_sp(16'h01e0, 32);
    rd_sp();
    `CHK(ovd, 1'h1)
    od_clr <= 1'h1;
    @(posedge ref_clk);
    od_clr <= 1'h0;
    @(posedge ref_clk);
    `CHK(ovd, 1'h0)
    report_and_stop();
  end
endmodule

`default_nettype wire
